/* hdl/scds_speed_dir.sv */
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "scds_consts.svh"

// Functional notes
// - Direction method 0 uses setpoint sign; 1 uses sign input, on means negative.
// - Analog polarity 0: positive voltage gives positive rotation, negative gives negative.
// - Analog polarity 1 inverts: positive voltage gives negative rotation.
// - Analog polarity setting resets to 1, the inverting setting.
// - Eight signed setpoints, range -20000 to 20000, reset to zero.
// - Source setting 3: three select lines pick one of eight setpoints.

module scds_speed_dir
    import scds_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host pins
    input  wire logic        speedSelectLine1,
    input  wire logic        speedSelectLine2,
    input  wire logic        speedSelectLine3,
    input  wire logic        speedSignInput,
    input  wire scds_speed_t analogSpeedInput,
    // Conditioned command
    output scds_speed_t      internalSpeedCmd,
    output logic             internalSpeedNeg,
    output scds_speed_t      analogSpeedCmd,
    output logic             analogSpeedNeg
);
    // ****************************************
    // Control register
    // ****************************************
    scds_ctrl_t ctrl;

    function automatic scds_speed_t clampSpeed(input logic [31:0] raw);
        scds_speed_t v;
        v = scds_speed_t'(raw[15:0]);
        if ($signed(raw) > 32'sd20000) begin
            v = `SCDS_SPEED_MAX;
        end else if ($signed(raw) < -32'sd20000) begin
            v = `SCDS_SPEED_MIN;
        end
        return v;
    endfunction

    // ****************************************
    // APB decode
    // ****************************************
    wire logic access    = psel && penable;
    wire logic hitCtrl   = paddr == `SCDS_OFF_CTRL;
    wire logic hitStatus = paddr == `SCDS_OFF_STATUS;
    wire logic hitAnalog = paddr == `SCDS_OFF_ANALOG;
    wire logic hitCmd    = paddr == `SCDS_OFF_CMD;
    wire logic hitSpeed  = paddr >= `SCDS_OFF_SPEED0 && paddr <= `SCDS_OFF_SPEED_LAST
                           && paddr[1:0] == 2'h0;
    wire logic hitAny    = hitCtrl || hitStatus || hitAnalog || hitCmd || hitSpeed;
    wire logic [2:0] speedIdx = paddr[4:2];
    wire logic tableWrite = access && pwrite && hitSpeed;
    // Setpoint reads take one wait state because the table read is registered
    logic readWait;
    wire logic slowRead = access && !pwrite && hitSpeed && !readWait;

    assign pready  = !slowRead;
    assign pslverr = access && !hitAny;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            readWait <= 1'h0;
        end else begin
            readWait <= slowRead;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl.directionMethodSetting <= `SCDS_DIR_RESET;
            ctrl.analogPolaritySetting  <= `SCDS_POL_RESET;
            ctrl.speedSourceSetting     <= `SCDS_SRC_RESET;
        end else if (access && pwrite && hitCtrl) begin
            ctrl.directionMethodSetting <= pwdata[`SCDS_CTRL_DIR_BIT];
            ctrl.analogPolaritySetting  <= pwdata[`SCDS_CTRL_POL_BIT];
            ctrl.speedSourceSetting     <= pwdata[`SCDS_CTRL_SRC_MSB:`SCDS_CTRL_SRC_LSB];
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    scds_pins_t pinSync1;
    scds_pins_t pinSync2;
    scds_pins_t pinSync3;
    scds_pins_t pins;
    wire scds_pins_t pinRaw = '{speedSelect: {speedSelectLine3, speedSelectLine2,
                                              speedSelectLine1},
                                speedSign: speedSignInput};

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pinSync1 <= '0;
            pinSync2 <= '0;
            pinSync3 <= '0;
            pins     <= '0;
        end else begin
            pinSync1 <= pinRaw;
            pinSync2 <= pinSync1;
            pinSync3 <= pinSync2;
            if (pinSync2 == pinSync3) begin
                pins <= pinSync3;
            end
        end
    end

    // ****************************************
    // Setpoint table and selection
    // ****************************************
    // Sources other than 3 use only the first four slots; line 3 is ignored
    wire logic [2:0] selIdx = (ctrl.speedSourceSetting == `SCDS_SRC_INTERNAL8) ?
                              pins.speedSelect : {1'h0, pins.speedSelect[1:0]};
    scds_speed_t busSpeed;
    scds_speed_t selSpeed;

    scds_speed_table scds_speed_table_i (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .writeEn   (tableWrite),
        .writeIdx  (speedIdx),
        .writeData (clampSpeed(pwdata)),
        .busIdx    (speedIdx),
        .busData   (busSpeed),
        .selIdx    (selIdx),
        .selData   (selSpeed)
    );

    // ****************************************
    // Direction resolution
    // ****************************************
    wire scds_speed_t selMag   = selSpeed[15] ? scds_speed_t'(-selSpeed) : selSpeed;
    wire logic        next_neg = ctrl.directionMethodSetting ?
                                 pins.speedSign : selSpeed[15];
    wire logic        anaNeg   = analogSpeedInput[15] ^ ctrl.analogPolaritySetting;
    wire logic        anaZero  = analogSpeedInput == `SCDS_SPEED_RESET;
    wire scds_speed_t anaMag   = analogSpeedInput[15] ?
                                 scds_speed_t'(-analogSpeedInput) : analogSpeedInput;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            internalSpeedCmd <= `SCDS_SPEED_RESET;
            internalSpeedNeg <= 1'h0;
            analogSpeedCmd   <= `SCDS_SPEED_RESET;
            analogSpeedNeg   <= 1'h0;
        end else begin
            internalSpeedNeg <= next_neg && selMag != `SCDS_SPEED_RESET;
            internalSpeedCmd <= next_neg ? scds_speed_t'(-selMag) : selMag;
            analogSpeedNeg   <= anaNeg && !anaZero;
            analogSpeedCmd   <= anaNeg ? scds_speed_t'(-anaMag) : anaMag;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    wire logic [31:0] ctrlWord = {26'h0, ctrl.speedSourceSetting, 2'h0,
                                  ctrl.analogPolaritySetting, ctrl.directionMethodSetting};
    wire logic [31:0] statWord = {27'h0, pins.speedSign, pins.speedSelect, internalSpeedNeg};

    always_comb begin
        prdata = 32'h0;
        if (hitCtrl) begin
            prdata = ctrlWord;
        end else if (hitStatus) begin
            prdata = statWord;
        end else if (hitAnalog) begin
            prdata = {{16{analogSpeedCmd[15]}}, analogSpeedCmd};
        end else if (hitCmd) begin
            prdata = {{16{internalSpeedCmd[15]}}, internalSpeedCmd};
        end else if (hitSpeed) begin
            prdata = {{16{busSpeed[15]}}, busSpeed};
        end
    end
endmodule

/* hdl/scds_speed_table.sv */
`timescale 1ns/1ps
`include "scds_consts.svh"

module scds_speed_table
    import scds_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Write port
    input  wire logic        writeEn,
    input  wire logic [2:0]  writeIdx,
    input  wire scds_speed_t writeData,
    // Read ports, registered
    input  wire logic [2:0]  busIdx,
    output scds_speed_t      busData,
    input  wire logic [2:0]  selIdx,
    output scds_speed_t      selData
);
    scds_speed_t mem [`SCDS_SPEED_COUNT];

    // ****************************************
    // Eight setpoints, each cleared at reset
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `SCDS_SPEED_COUNT; g++) begin : gSlot
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    mem[g] <= `SCDS_SPEED_RESET;
                end else if (writeEn && writeIdx == 3'(g)) begin
                    mem[g] <= writeData;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busData <= `SCDS_SPEED_RESET;
            selData <= `SCDS_SPEED_RESET;
        end else begin
            busData <= mem[busIdx];
            selData <= mem[selIdx];
        end
    end
endmodule

/* pkg/scds_consts.svh */
`ifndef SCDS_CONSTS_SVH
`define SCDS_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SCDS_OFF_CTRL       12'h000
`define SCDS_OFF_STATUS     12'h004
`define SCDS_OFF_ANALOG     12'h008
`define SCDS_OFF_CMD        12'h00c
`define SCDS_OFF_SPEED0     12'h020
`define SCDS_OFF_SPEED_LAST 12'h03c

// ****************************************
// Control fields and reset values
// ****************************************
`define SCDS_CTRL_DIR_BIT   0
`define SCDS_CTRL_POL_BIT   1
`define SCDS_CTRL_SRC_LSB   4
`define SCDS_CTRL_SRC_MSB   5
`define SCDS_DIR_RESET      1'h0
`define SCDS_POL_RESET      1'h1
`define SCDS_SRC_RESET      2'h0
`define SCDS_SRC_INTERNAL8  2'h3
`define SCDS_SPEED_RESET    16'sh0000
`define SCDS_SPEED_MAX      16'sh4e20
`define SCDS_SPEED_MIN      16'shb1e0
`define SCDS_SPEED_COUNT    8

`endif

/* pkg/scds_pkg.sv */
package scds_pkg;
    typedef logic signed [15:0] scds_speed_t;

    typedef struct packed {
        logic       directionMethodSetting;
        logic       analogPolaritySetting;
        logic [1:0] speedSourceSetting;
    } scds_ctrl_t;

    typedef struct packed {
        logic [2:0] speedSelect;
        logic       speedSign;
    } scds_pins_t;
endpackage

/* testbench/scds_host_model.sv */
`timescale 1ns/1ps
// ****
// Host controller model
// ****
module scds_host_model
    import scds_pkg::*;
(
    // Clock and requested state
    input  wire logic        core_clk,
    input  wire scds_pins_t  want,
    input  wire scds_speed_t wantAnalog,
    // Host pins
    output scds_pins_t       pins,
    output scds_speed_t      analog
);
    logic [2:0] diff;
    assign diff = pins.speedSelect ^ want.speedSelect;
    initial pins = '0;
    initial analog = '0;
    // Moving two lines at once could pass through an unwanted setpoint
    always @(posedge core_clk) begin
        pins.speedSign   <= want.speedSign;
        analog           <= wantAnalog;
        pins.speedSelect <= pins.speedSelect ^ (diff & (~diff + 3'h1));
    end
endmodule

/* testbench/scds_speed_dir_asserts.sv */
`timescale 1ns/1ps
`include "scds_consts.svh"
// ****
// Port checker
// ****
module scds_speed_dir_asserts
    import scds_pkg::*;
(
    // Clock, reset and bus
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Speed path
    input wire scds_speed_t analogSpeedInput,
    input wire scds_speed_t internalSpeedCmd,
    input wire logic        internalSpeedNeg,
    input wire scds_speed_t analogSpeedCmd,
    input wire logic        analogSpeedNeg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire access = psel && penable;
    chk_reset_idle: assert property ($rose(reset_n) |-> internalSpeedCmd == 0 && pready)
        else $error("outputs not idle after reset");
    chk_write_nowait: assert property (access && pwrite |-> pready)
        else $error("write stalled");
    chk_read_wait: assert property (psel && !penable && !pwrite && paddr[11:5] == 7'h01
        |=> !pready ##1 pready) else $error("setpoint read wait wrong");
    chk_unmapped_err: assert property (access && paddr == 12'h010 |-> pslverr)
        else $error("unmapped access accepted");
    chk_int_sign: assert property (internalSpeedNeg == (internalSpeedCmd < 0))
        else $error("direction flag disagrees with command");
    chk_int_range: assert property (internalSpeedCmd <= `SCDS_SPEED_MAX
        && internalSpeedCmd >= `SCDS_SPEED_MIN) else $error("command out of range");
    chk_analog_map: assert property (analogSpeedCmd == $past(analogSpeedInput)
        || analogSpeedCmd == -$past(analogSpeedInput)) else $error("analog map wrong");
    chk_analog_sign: assert property (analogSpeedNeg == (analogSpeedCmd < 0))
        else $error("analog flag disagrees");
    cover property (access && pslverr);
    cover property (internalSpeedNeg);
    cover property (analogSpeedNeg);
endmodule

bind scds_speed_dir scds_speed_dir_asserts scds_speed_dir_asserts_i (.core_clk, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .analogSpeedInput,
    .internalSpeedCmd, .internalSpeedNeg, .analogSpeedCmd, .analogSpeedNeg);

/* testbench/speed_command_direction_select_bench.sv */
`timescale 1ns/1ps
`include "scds_consts.svh"
module speed_command_direction_select_bench import scds_pkg::*;;
    logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
    logic        internalSpeedNeg, analogSpeedNeg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    scds_speed_t analogSpeedInput, internalSpeedCmd, analogSpeedCmd, wantAnalog, ex;
    scds_pins_t  want, pins;
    int          nMismatch, compares;
    scds_speed_t sp [8];
    logic [31:0] wv [8] = '{32'h7530, 32'hffff8ad0, 32'h1, 32'hffffffff, 32'h0, 32'h5dc,
                            32'hfffffff9, 32'h4e20};
    scds_speed_dir scds_speed_dir_i (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .speedSelectLine1(pins.speedSelect[0]),
        .speedSelectLine2(pins.speedSelect[1]), .speedSelectLine3(pins.speedSelect[2]),
        .speedSignInput(pins.speedSign), .analogSpeedInput, .internalSpeedCmd,
        .internalSpeedNeg, .analogSpeedCmd, .analogSpeedNeg);
    scds_host_model scds_host_model_i (.core_clk, .want, .wantAnalog, .pins,
        .analog(analogSpeedInput));
    // ****
    // Tasks
    // ****
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            nMismatch++;
            test_done;
        end else begin
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, nMismatch, compares} = '0;
        want = '0;
        wantAnalog = '0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        @(posedge core_clk);
        apb(0, 12'h000, 0);
        chk("ctrl", q, 32'h2);
        apb(0, 12'h010, 0);
        chk("err", e, 1'b1);
        for (int i = 0; i < 8; i++) begin
            apb(0, 12'h020 + 12'(4 * i), 0);
            chk("reset", q, 0);
            apb(1, 12'h020 + 12'(4 * i), wv[i]);
            sp[i] = $signed(wv[i]) > `SCDS_SPEED_MAX ? `SCDS_SPEED_MAX :
                    $signed(wv[i]) < `SCDS_SPEED_MIN ? `SCDS_SPEED_MIN : wv[i][15:0];
            apb(0, 12'h020 + 12'(4 * i), 0);
            chk("speed", q, {{16{sp[i][15]}}, sp[i]});
        end
        for (int d = 0; d < 2; d++) begin
            apb(1, 12'h000, 32'h30 | d);
            for (int i = 0; i < 16; i++) begin
                want <= {3'(i >> 1), i[0]};
                repeat (12) @(posedge core_clk);
                @(negedge core_clk);
                ex = sp[i >> 1] < 0 ? -sp[i >> 1] : sp[i >> 1];
                ex = d ? (i[0] ? -ex : ex) : sp[i >> 1];
                chk("cmd", internalSpeedCmd, ex);
                chk("neg", internalSpeedNeg, ex < 0);
                @(posedge core_clk);
                apb(0, 12'h00c, 0);
                chk("cmdreg", q, {{16{ex[15]}}, ex});
                apb(0, 12'h004, 0);
                chk("status", q, {27'h0, i[0], 3'(i >> 1), ex < 0});
            end
        end
        for (int p = 0; p < 4; p++) begin
            apb(1, 12'h000, 32'(p & 2));
            wantAnalog <= p[0] ? 16'shfb2e : 16'sh04d2;
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            ex = p[1] ? -wantAnalog : wantAnalog;
            chk("analog", analogSpeedCmd, ex);
            chk("aneg", analogSpeedNeg, ex < 0);
            chk("src", internalSpeedCmd, sp[3]);
            @(posedge core_clk);
            apb(0, 12'h008, 0);
            chk("anareg", q, {{16{ex[15]}}, ex});
        end
        test_done;
    end
endmodule
